/* File: hw/emc_pkg.sv */
// shared constants for the external memory interface configuration block
package emc_pkg;
  // register indexes; the apb byte addresses are the index times four (index 0x85 is byte 0x214)
  localparam logic [7:0] EMC_IDX_CONFIG = 8'h85;
  localparam logic [7:0] EMC_IDX_PAGE = 8'h86;
  localparam logic [7:0] EMC_IDX_STATUS = 8'h87;
  localparam logic [11:0] EMC_ADDR_CONFIG = {2'h0, EMC_IDX_CONFIG, 2'h0};
  localparam logic [11:0] EMC_ADDR_PAGE = {2'h0, EMC_IDX_PAGE, 2'h0};
  localparam logic [11:0] EMC_ADDR_STATUS = {2'h0, EMC_IDX_STATUS, 2'h0};
  localparam int EMC_PADDR_W = 12;
  // configuration register fields
  localparam int EMC_FIFO_WIN_BIT = 6;
  localparam int EMC_SHARED_BIT = 4;
  localparam int EMC_MAP_LSB = 2;
  localparam int EMC_STROBE_LSB = 0;
  localparam logic [7:0] EMC_CONFIG_WMASK = 8'h5F;
  localparam logic [7:0] EMC_CONFIG_RST = 8'h03;
  localparam logic [7:0] EMC_PAGE_RST = 8'h00;
  // memory map selections
  localparam logic [1:0] EMC_MAP_ONCHIP = 2'h0;
  localparam logic [1:0] EMC_MAP_SPLIT_NB = 2'h1;
  localparam logic [1:0] EMC_MAP_SPLIT_B = 2'h2;
  localparam logic [1:0] EMC_MAP_OFFCHIP = 2'h3;
  // fifo window
  localparam logic [15:0] EMC_WIN_LO = 16'h0400;
  localparam logic [15:0] EMC_WIN_HI = 16'h07FF;
  localparam logic [15:0] EMC_ONCHIP_SIZE_DEF = 16'h1000;
  localparam logic [15:0] EMC_ADDR_ZERO = 16'h0000;
  localparam logic [7:0] EMC_BYTE_ZERO = 8'h00;
  localparam logic [31:0] EMC_WORD_ZERO = 32'h00000000;
  // access targets
  typedef enum logic [1:0] {EMC_TGT_ONCHIP, EMC_TGT_FIFO, EMC_TGT_OFFCHIP} emc_target_t;
endpackage : emc_pkg

/* File: hw/emc_decode.sv */
// address routing for one data-move access
`timescale 1ns/1ps
module emc_decode import emc_pkg::*; #(
  parameter logic [15:0] ONCHIP_SIZE = EMC_ONCHIP_SIZE_DEF
) (
  input wire logic [15:0] eff_addr, // full effective address
  input wire logic [1:0] map_sel, // memory map select
  input wire logic win_en, // fifo window enable
  output emc_target_t target, // where the access goes
  output logic [15:0] local_addr // address inside the target
);
  always_comb begin
    local_addr = eff_addr;
    if (win_en && eff_addr >= EMC_WIN_LO && eff_addr <= EMC_WIN_HI) begin
      target = EMC_TGT_FIFO;
      local_addr = eff_addr - EMC_WIN_LO;
    end else begin
      case (map_sel)
        EMC_MAP_ONCHIP: begin
          target = EMC_TGT_ONCHIP;
          local_addr = eff_addr & (ONCHIP_SIZE - 16'h0001);
        end
        EMC_MAP_SPLIT_NB, EMC_MAP_SPLIT_B: begin
          target = (eff_addr < ONCHIP_SIZE) ? EMC_TGT_ONCHIP : EMC_TGT_OFFCHIP;
        end
        default: begin
          target = EMC_TGT_OFFCHIP;
        end
      endcase
    end
  end
endmodule : emc_decode

/* File: hw/emc_strobe.sv */
// address latch strobe timer: high then low, each for a set number of cycles
`timescale 1ns/1ps
module emc_strobe import emc_pkg::*; (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic start, // begin a strobe pulse
  input wire logic [1:0] width, // cycles minus one per phase
  output logic strobe, // latch strobe level
  output logic busy // pulse in progress
);
  typedef enum logic [1:0] {EMC_S_IDLE, EMC_S_HIGH, EMC_S_LOW} emc_sph_t;
  typedef struct packed {
    emc_sph_t ph;
    logic [1:0] cnt;
    logic [1:0] w;
  } emc_strobe_st_t;
  emc_strobe_st_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    case (st_r.ph)
      EMC_S_IDLE: begin
        if (start) begin
          st_nxt.ph = EMC_S_HIGH;
          st_nxt.cnt = 2'h0;
          st_nxt.w = width;
        end
      end
      EMC_S_HIGH: begin
        st_nxt.cnt = st_r.cnt + 2'h1;
        if (st_r.cnt == st_r.w) begin
          st_nxt.ph = EMC_S_LOW;
          st_nxt.cnt = 2'h0;
        end
      end
      EMC_S_LOW: begin
        st_nxt.cnt = st_r.cnt + 2'h1;
        if (st_r.cnt == st_r.w) begin
          st_nxt.ph = EMC_S_IDLE;
        end
      end
      default: st_nxt.ph = EMC_S_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign strobe = (st_r.ph == EMC_S_HIGH);
  assign busy = (st_r.ph != EMC_S_IDLE);

  a_strobe_high_len: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(strobe) |-> strobe [*1] ##0 (st_r.w == $past(width)))
    else $error("strobe width not captured at start");
endmodule : emc_strobe

/* File: hw/emc_top.sv */
// external memory interface configuration, routing and bus address generation
//
// Function
// - with the fifo window enabled, data moves to 0x0400..0x07FF reach the usb packet ram.
// - with the window disabled, data moves never reach the usb packet ram.
// - while the window is enabled, normal memory at the window addresses is unreachable.
// - shared_bus_select 0 multiplexes low address and data, 1 uses separate pins.
// - map select 00 sends every access outside an enabled fifo window on-chip, aliasing addresses into on-chip ram.
// - map select 01 or 10 sends addresses below the on-chip size on-chip, others off-chip.
// - map select 01 leaves the upper address byte of 8-bit off-chip moves to the port latches.
// - map select 10 drives the upper byte of 8-bit off-chip moves from the page register.
// - map select 11 sends every access outside an enabled fifo window off-chip and hides on-chip ram.
// - the strobe width field sets high and low strobe time to 1..4 system clock cycles.
// - the strobe width only matters in multiplexed operation.
// - the two unused configuration bits read zero and ignore writes.
// - for 8-bit moves the page register supplies the high address byte.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module emc_top import emc_pkg::*; #(
  parameter logic [15:0] ONCHIP_SIZE = EMC_ONCHIP_SIZE_DEF
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [EMC_PADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic mv_req, // data-move request pulse
  input wire logic mv_short, // 8-bit addressed form
  input wire logic [15:0] mv_addr, // 16-bit pointer or low byte in [7:0]
  output logic [1:0] mv_target, // routed target of last request
  output logic [15:0] mv_local, // address within that target
  output logic [15:0] ext_addr, // off-chip address bus
  output logic ext_addr_hi_oe, // upper address byte driven
  output logic ext_addr_lo_oe, // lower address byte driven
  output logic ext_muxed, // low address shares data pins
  output logic ext_strobe, // address latch strobe
  output logic fifo_sel, // usb packet ram selected
  output logic onchip_sel, // on-chip ram selected
  output logic offchip_sel // off-chip access selected
);
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] page;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [1:0] tgt;
    logic [15:0] loc;
    logic [15:0] ea;
    logic hi_oe;
    logic lo_oe;
    logic muxed;
    logic strobe;
    logic fifo;
    logic onc;
    logic offc;
    logic strobe_go;
  } emc_state_t;
  emc_state_t st_r, st_nxt;

  logic [15:0] eff_addr;
  emc_target_t dec_target;
  logic [15:0] dec_local;
  logic strobe_lvl;
  logic strobe_busy;
  logic apb_xfer;
  logic [1:0] cfg_map;

  assign cfg_map = st_r.cfg[EMC_MAP_LSB +: 2];
  assign apb_xfer = psel && penable && !st_r.ready;
  // the page register provides the high byte for short moves
  assign eff_addr = mv_short ? {st_r.page, mv_addr[7:0]} : mv_addr;

  emc_decode #(
    .ONCHIP_SIZE(ONCHIP_SIZE)
  ) u_decode (
    .eff_addr(eff_addr),
    .map_sel(cfg_map),
    .win_en(st_r.cfg[EMC_FIFO_WIN_BIT]),
    .target(dec_target),
    .local_addr(dec_local)
  );

  emc_strobe u_strobe (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(st_r.strobe_go),
    .width(st_r.cfg[EMC_STROBE_LSB +: 2]),
    .strobe(strobe_lvl),
    .busy(strobe_busy)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.ready = 1'b0;
    st_nxt.err = 1'b0;
    st_nxt.strobe_go = 1'b0;
    st_nxt.strobe = strobe_lvl;
    st_nxt.muxed = !st_r.cfg[EMC_SHARED_BIT];
    // apb: one wait state, answer in the second access cycle
    if (apb_xfer) begin
      st_nxt.ready = 1'b1;
      st_nxt.rdata = EMC_WORD_ZERO;
      case (paddr)
        EMC_ADDR_CONFIG: begin
          if (pwrite) begin
            st_nxt.cfg = pwdata[7:0] & EMC_CONFIG_WMASK;
          end else begin
            st_nxt.rdata = {24'h000000, st_r.cfg};
          end
        end
        EMC_ADDR_PAGE: begin
          if (pwrite) begin
            st_nxt.page = pwdata[7:0];
          end else begin
            st_nxt.rdata = {24'h000000, st_r.page};
          end
        end
        EMC_ADDR_STATUS: begin
          if (!pwrite) begin
            st_nxt.rdata = {EMC_BYTE_ZERO, st_r.ea, 5'h00, strobe_busy, st_r.tgt};
          end
        end
        default: begin
          st_nxt.err = 1'b1;
        end
      endcase
    end
    if (mv_req) begin
      st_nxt.tgt = dec_target;
      st_nxt.loc = dec_local;
      st_nxt.fifo = (dec_target == EMC_TGT_FIFO);
      st_nxt.onc = (dec_target == EMC_TGT_ONCHIP);
      st_nxt.offc = (dec_target == EMC_TGT_OFFCHIP);
      st_nxt.hi_oe = 1'b0;
      st_nxt.lo_oe = 1'b0;
      if (dec_target == EMC_TGT_OFFCHIP) begin
        st_nxt.ea = eff_addr;
        st_nxt.lo_oe = 1'b1;
        st_nxt.hi_oe = 1'b1;
        // short moves in no-bank and off-chip-only maps keep port latches
        if (mv_short && cfg_map != EMC_MAP_SPLIT_B) begin
          st_nxt.hi_oe = 1'b0;
        end
        // only a multiplexed bus needs the address latch strobe
        st_nxt.strobe_go = !st_r.cfg[EMC_SHARED_BIT] && !strobe_busy;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.cfg <= EMC_CONFIG_RST;
      st_r.page <= EMC_PAGE_RST;
      st_r.muxed <= 1'b1;
      st_r.ea <= EMC_ADDR_ZERO;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.err;
  assign mv_target = st_r.tgt;
  assign mv_local = st_r.loc;
  assign ext_addr = st_r.ea;
  assign ext_addr_hi_oe = st_r.hi_oe;
  assign ext_addr_lo_oe = st_r.lo_oe;
  assign ext_muxed = st_r.muxed;
  assign ext_strobe = st_r.strobe;
  assign fifo_sel = st_r.fifo;
  assign onchip_sel = st_r.onc;
  assign offchip_sel = st_r.offc;

  a_win_hit: assert property (@(posedge clk) disable iff (sys_rst)
    mv_req && st_r.cfg[EMC_FIFO_WIN_BIT] && eff_addr >= EMC_WIN_LO && eff_addr <= EMC_WIN_HI
    |=> fifo_sel && !onchip_sel && !offchip_sel)
    else $error("window access not routed to usb ram");
  a_win_off: assert property (@(posedge clk) disable iff (sys_rst)
    mv_req && !st_r.cfg[EMC_FIFO_WIN_BIT] |=> !fifo_sel)
    else $error("usb ram reached with window disabled");
  a_win_shadow: assert property (@(posedge clk) disable iff (sys_rst)
    mv_req && st_r.cfg[EMC_FIFO_WIN_BIT] && eff_addr[15:10] == 6'h01 |=> !offchip_sel)
    else $error("normal memory reached under window");
  a_bus_form: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 ext_muxed == !$past(st_r.cfg[EMC_SHARED_BIT]))
    else $error("bus form does not follow shared select");
  a_map_onchip: assert property (@(posedge clk) disable iff (sys_rst)
    mv_req && cfg_map == EMC_MAP_ONCHIP && !(st_r.cfg[EMC_FIFO_WIN_BIT] && eff_addr[15:10] == 6'h01)
    |=> onchip_sel && mv_local < ONCHIP_SIZE)
    else $error("internal-only map did not alias on-chip");
  a_map_split: assert property (@(posedge clk) disable iff (sys_rst)
    mv_req && (cfg_map == EMC_MAP_SPLIT_NB || cfg_map == EMC_MAP_SPLIT_B)
    && !st_r.cfg[EMC_FIFO_WIN_BIT] |=> offchip_sel == ($past(eff_addr) >= ONCHIP_SIZE))
    else $error("split map boundary wrong");
  a_hi_nodrive: assert property (@(posedge clk) disable iff (sys_rst)
    mv_req && mv_short && cfg_map == EMC_MAP_SPLIT_NB |=> !ext_addr_hi_oe)
    else $error("upper byte driven without bank select");
  a_hi_bank: assert property (@(posedge clk) disable iff (sys_rst)
    mv_req && mv_short && cfg_map == EMC_MAP_SPLIT_B && dec_target == EMC_TGT_OFFCHIP
    |=> ext_addr_hi_oe && ext_addr[15:8] == $past(st_r.page))
    else $error("bank select upper byte wrong");
  a_map_offchip: assert property (@(posedge clk) disable iff (sys_rst)
    mv_req && cfg_map == EMC_MAP_OFFCHIP && !st_r.cfg[EMC_FIFO_WIN_BIT] |=> offchip_sel)
    else $error("external-only map went on-chip");
  a_strobe_mux: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.cfg[EMC_SHARED_BIT] && !strobe_busy |=> !st_r.strobe_go)
    else $error("strobe started on separate bus");
  a_unused_zero: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.cfg[7] == 1'b0 && st_r.cfg[5] == 1'b0)
    else $error("unused config bits set");
endmodule : emc_top

/* File: bench/emc_xmem_model.sv */
// off-chip side model: external address latch and parked upper address pins
`timescale 1ns/1ps
module emc_xmem_model (
  input wire logic [15:0] ext_addr, // address bus from the block
  input wire logic ext_addr_hi_oe, // upper byte driven by the block
  input wire logic ext_muxed, // low address shares the data pins
  input wire logic ext_strobe, // address latch strobe
  input wire logic [7:0] park_hi, // port latch level of the upper pins
  output logic [7:0] pin_hi, // level seen on the upper pins
  output logic [7:0] latch_q // latched low address
);
  // undriven upper pins show the port latches, never the block's last value
  assign pin_hi = ext_addr_hi_oe ? ext_addr[15:8] : park_hi;
  // transparent while the strobe is high, holds after it falls
  always_latch begin
    if (ext_muxed && ext_strobe) begin
      latch_q <= ext_addr[7:0];
    end
  end
endmodule : emc_xmem_model

/* File: bench/emc_top_bench.sv */
// self-checking bench for the external memory configuration and routing block
`timescale 1ns/1ps
module emc_top_bench import emc_pkg::*; ;
  typedef struct packed {logic [7:0] cfg; logic [7:0] pg; logic sh; logic [15:0] a;
    logic [1:0] tgt; logic [15:0] ex; logic hi;} emc_row_t;
  // config, page, short form, address, target, local or bus address, upper byte driven
  emc_row_t rows [12] = '{
    '{8'h13, 8'h00, 1'b0, 16'h1234, 2'h0, 16'h0234, 1'b0},
    '{8'h53, 8'h00, 1'b0, 16'h0500, 2'h1, 16'h0100, 1'b0},
    '{8'h13, 8'h00, 1'b0, 16'h0500, 2'h0, 16'h0500, 1'b0},
    '{8'h17, 8'h00, 1'b0, 16'h0100, 2'h0, 16'h0100, 1'b0},
    '{8'h17, 8'h00, 1'b0, 16'h1234, 2'h2, 16'h1234, 1'b1},
    '{8'h17, 8'h12, 1'b1, 16'h0034, 2'h2, 16'h1234, 1'b0},
    '{8'h1B, 8'h12, 1'b1, 16'h0056, 2'h2, 16'h1256, 1'b1},
    '{8'h1B, 8'h03, 1'b1, 16'h0010, 2'h0, 16'h0310, 1'b0},
    '{8'h1F, 8'h00, 1'b0, 16'h0010, 2'h2, 16'h0010, 1'b1},
    '{8'h5F, 8'h00, 1'b0, 16'h0400, 2'h1, 16'h0000, 1'b0},
    '{8'h5B, 8'h00, 1'b0, 16'h07FF, 2'h1, 16'h03FF, 1'b0},
    '{8'h5B, 8'h00, 1'b0, 16'h0800, 2'h2, 16'h0800, 1'b1}
  };
  emc_row_t r;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mv_req = 1'b0, mv_short = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [15:0] mv_addr = 16'h0000;
  logic [31:0] prdata, rd;
  logic [15:0] mv_local, ext_addr, sv, ev;
  logic [7:0] pin_hi, latch_q;
  logic [1:0] mv_target;
  logic pready, pslverr, er, hi_oe, lo_oe, ext_muxed, ext_strobe;
  logic fifo_sel, onchip_sel, offchip_sel;
  int errors = 0;
  int num_checks = 0;

  always #12.5 clk = ~clk;

  emc_top #(.ONCHIP_SIZE(16'h0800)) emc_top_i (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mv_req(mv_req), .mv_short(mv_short),
    .mv_addr(mv_addr), .mv_target(mv_target), .mv_local(mv_local), .ext_addr(ext_addr),
    .ext_addr_hi_oe(hi_oe), .ext_addr_lo_oe(lo_oe), .ext_muxed(ext_muxed),
    .ext_strobe(ext_strobe), .fifo_sel(fifo_sel), .onchip_sel(onchip_sel),
    .offchip_sel(offchip_sel));

  emc_xmem_model emc_xmem_model_i (.ext_addr(ext_addr), .ext_addr_hi_oe(hi_oe),
    .ext_muxed(ext_muxed), .ext_strobe(ext_strobe), .park_hi(8'hFF), .pin_hi(pin_hi),
    .latch_q(latch_q));

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // the request stays up until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic move(input logic sh, input logic [15:0] a);
    @(posedge clk);
    mv_req <= 1'b1;
    mv_short <= sh;
    mv_addr <= a;
    @(posedge clk);
    mv_req <= 1'b0;
    #1;
  endtask : move

  // records the strobe from the cycle after the request is taken
  task automatic watch(input int n);
    sv = 16'h0000;
    for (int k = 0; k < n; k++) begin
      sv[k] = ext_strobe;
      @(posedge clk);
      #1;
    end
  endtask : watch

  initial begin
    #(25 * 5000);
    errors++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'b1, EMC_ADDR_CONFIG, {24'h000000, r.cfg}, rd, er);
      apb(1'b1, EMC_ADDR_PAGE, {24'h000000, r.pg}, rd, er);
      move(r.sh, r.a);
      chk("target", {30'h0, r.tgt}, {30'h0, mv_target});
      chk("select", {r.tgt == 2'h1, r.tgt == 2'h0, r.tgt == 2'h2},
        {fifo_sel, onchip_sel, offchip_sel});
      chk("lo_oe", {31'h0, r.tgt == 2'h2}, {31'h0, lo_oe});
      if (r.tgt == 2'h2) begin
        chk("ext_addr", r.ex, ext_addr);
        chk("hi_oe", r.hi, hi_oe);
        chk("pin_hi", r.hi ? r.ex[15:8] : 8'hFF, pin_hi);
      end else begin
        chk("local", r.ex, mv_local);
      end
    end
    for (int w = 0; w < 4; w++) begin
      apb(1'b1, EMC_ADDR_CONFIG, 32'h0000000C + 32'(w), rd, er);
      move(1'b0, 16'h1234);
      watch(2 * w + 4);
      ev = 16'h0000;
      // strobe level is registered twice: it shows from the third sample on
      for (int k = 2; k <= w + 2; k++) ev[k] = 1'b1;
      chk("strobe", ev, sv);
      chk("latch", 32'h34, latch_q);
      chk("muxed", 32'h1, ext_muxed);
    end
    apb(1'b1, EMC_ADDR_CONFIG, 32'h0000001F, rd, er);
    move(1'b0, 16'h1234);
    watch(10);
    chk("strobe", 32'h0, sv);
    chk("muxed", 32'h0, ext_muxed);
    apb(1'b0, EMC_ADDR_STATUS, 32'h0, rd, er);
    chk("status", 32'h00123402, rd);
    apb(1'b1, EMC_ADDR_CONFIG, 32'hFFFFFFFF, rd, er);
    apb(1'b0, EMC_ADDR_CONFIG, 32'h0, rd, er);
    chk("config", 32'h5F, rd);
    chk("slverr", 32'h0, er);
    apb(1'b1, EMC_ADDR_PAGE, 32'h000000A5, rd, er);
    apb(1'b0, EMC_ADDR_PAGE, 32'h0, rd, er);
    chk("page", 32'hA5, rd);
    apb(1'b1, 12'h100, 32'h000000FF, rd, er);
    chk("slverr", 32'h1, er);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("muxed", 32'h1, ext_muxed);
    chk("reset_sel", 32'h0, {fifo_sel, onchip_sel, offchip_sel});
    apb(1'b0, EMC_ADDR_CONFIG, 32'h0, rd, er);
    chk("config", 32'h03, rd);
    apb(1'b0, EMC_ADDR_PAGE, 32'h0, rd, er);
    chk("page", 32'h00, rd);
    wrap_up();
  end
endmodule : emc_top_bench
